// ### include/wdn_pkg.sv
// Constants shared by the process-data watchdog and network-failure block
package wdn_pkg;

	// ------------------------------------------------------------
	// Register numbers (16-bit word registers)
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_TIMEOUT = 16'h07d0;
	localparam logic [15:0] ADDR_MODE    = 16'h07d2;
	localparam logic [15:0] ADDR_REASON  = 16'h07d4;
	localparam logic [15:0] ADDR_CMD     = 16'h07d6;
	localparam logic [15:0] ADDR_STATUS  = 16'h1f3c;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] RST_TIMEOUT    = 16'h0000;
	localparam logic [15:0] RST_MODE       = 16'h0000;
	localparam logic [15:0] RST_REASON     = 16'h0000;
	localparam logic [15:0] TIMEOUT_OFF    = 16'h0000;
	localparam logic [15:0] TIMEOUT_MIN_MS = 16'h00c8;
	localparam logic [15:0] TIMEOUT_MAX_MS = 16'hfde8;

	// ------------------------------------------------------------
	// Fault response modes and failure reason codes
	// ------------------------------------------------------------
	localparam logic [15:0] MODE_LOW   = 16'h0000;
	localparam logic [15:0] MODE_HIGH  = 16'h0001;
	localparam logic [15:0] MODE_HOLD  = 16'h0002;
	localparam logic [15:0] RSN_USER   = 16'h0009;
	localparam logic [15:0] RSN_WDOG   = 16'h000c;
	localparam logic [15:0] RSN_MODBUS = 16'h000d;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CMD_SET_FAIL_BIT = 4;
	localparam int CMD_ACK_BIT      = 5;
	localparam int CMD_CLR_WARN_BIT = 7;
	localparam int STAT_ERR_BIT     = 0;
	localparam int STAT_FAIL_BIT    = 1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned TICK_MS    = 1;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_FAIL = 2'b10
	} wdn_state_t;

endpackage : wdn_pkg

// ### rtl/wdn_watchdog.sv
// Process-data watchdog, fault response and network-failure control
//
// Contract
// - Timeout in ms, nonzero only 200..65000
// - Zero timeout keeps watchdog disabled
// - Mode selects outputs low, high, hold
// - Mode register write applies to later failures
// - Readable failure reason register
// - Reason codes: watchdog, Modbus, user command
// - Command needs exactly one bit, else error
// - Command register is write-only
// - Command bits: set, acknowledge, clear warning
// - Status bit 0 shows any error
// - Status bit 1 shows active network failure
// - Output writes start/restart watchdog, reads do not
// - Expiry applies substitutes, sets failure flag
// - Auto mode write or acknowledge clears failure
// - Acknowledge restarts the watchdog
module wdn_watchdog #(
	parameter int unsigned NOUT     = 4,
	parameter int unsigned TICK_CYC = wdn_pkg::CYC_PER_MS
) (
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              arst_n_in,
	// Register access
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	input  wire logic [15:0]       reg_addr_in,
	input  wire logic [15:0]       reg_wdata_in,
	output logic      [15:0]       reg_rdata_out,
	output logic                   reg_ack_out,
	output logic                   reg_err_out,
	// Output process data and events
	input  wire logic              pd_write_in,
	input  wire logic [NOUT-1:0]   pd_data_in,
	input  wire logic              modbus_timeout_in,
	input  wire logic              auto_confirm_in,
	input  wire logic              diag_error_in,
	// Device side results
	output logic      [NOUT-1:0]   out_value_out,
	output logic                   net_fail_out,
	output logic                   io_warn_clear_out
);
	import wdn_pkg::*;

	localparam int PW = $clog2(TICK_CYC + 1);
	localparam logic [PW-1:0] PLAST = PW'(TICK_CYC - 1);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (NOUT < 1 || NOUT > 16 || TICK_CYC < 1) begin : g_bad_param
		$error("wdn_watchdog: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// True when exactly one bit of the word is set
	function automatic logic one_hot(input logic [15:0] w);
		return (w != 16'h0000) && ((w & (w - 16'h0001)) == 16'h0000);
	endfunction : one_hot

	// Substitute pattern for a fault response mode
	function automatic logic [NOUT-1:0] subst(input logic [1:0] m,
			input logic [NOUT-1:0] held);
		logic [NOUT-1:0] r;
		r = '0;
		if (m == MODE_HIGH[1:0]) begin
			r = '1;
		end else if (m == MODE_HOLD[1:0]) begin
			r = held;
		end
		return r;
	endfunction : subst

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	wdn_state_t      state, next_state;
	logic [15:0]     timeout_ms, next_timeout_ms;
	logic [15:0]     fault_response_mode, next_fault_response_mode;
	logic [15:0]     failure_reason_code, next_failure_reason_code;
	logic [PW-1:0]   presc, next_presc;
	logic [15:0]     ms_cnt, next_ms_cnt;
	logic [NOUT-1:0] pd_q, next_pd_q;
	logic [NOUT-1:0] hold_q, next_hold_q;
	logic [1:0]      fail_mode, next_fail_mode;
	logic            cmd_err, next_cmd_err;
	logic [15:0]     next_rdata;
	logic            next_ack, next_err, next_warn_clr;
	logic [NOUT-1:0] next_out;
	logic            tick, expire, restart, cmd_set, cmd_ack, fail_evt;
	logic [15:0]     fail_rsn, status_word;

	// Any error includes a live failure, diagnostics and a refused command
	assign status_word = {14'h0000, state == ST_FAIL,
		diag_error_in | cmd_err | (state == ST_FAIL)};

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Reads take priority when a read and a write coincide
	always_comb begin
		next_state               = state;
		next_timeout_ms          = timeout_ms;
		next_fault_response_mode = fault_response_mode;
		next_failure_reason_code = failure_reason_code;
		next_presc               = presc;
		next_ms_cnt              = ms_cnt;
		next_pd_q                = pd_q;
		next_hold_q              = hold_q;
		next_fail_mode           = fail_mode;
		next_cmd_err             = cmd_err;
		next_rdata               = 16'h0000;
		next_ack                 = reg_wr_in | reg_rd_in;
		next_err                 = 1'b0;
		next_warn_clr            = 1'b0;
		cmd_set                  = 1'b0;
		cmd_ack                  = 1'b0;
		restart                  = 1'b0;
		expire                   = 1'b0;
		fail_evt                 = 1'b0;
		fail_rsn                 = RSN_MODBUS;
		tick                     = (state == ST_RUN) && (presc == PLAST);
		// Register access
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_TIMEOUT: next_rdata = timeout_ms;
				ADDR_MODE:    next_rdata = fault_response_mode;
				ADDR_REASON:  next_rdata = failure_reason_code;
				ADDR_STATUS:  next_rdata = status_word;
				default:      next_err   = 1'b1;
			endcase
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_TIMEOUT: begin
					// Once started the watchdog cannot be switched off
					if ((reg_wdata_in == TIMEOUT_OFF && state == ST_IDLE) ||
						(reg_wdata_in >= TIMEOUT_MIN_MS &&
						reg_wdata_in <= TIMEOUT_MAX_MS)) begin
						next_timeout_ms = reg_wdata_in;
					end else begin
						next_err = 1'b1;
					end
				end
				ADDR_MODE: begin
					if (reg_wdata_in <= MODE_HOLD) begin
						next_fault_response_mode = reg_wdata_in;
					end else begin
						next_err = 1'b1;
					end
				end
				ADDR_CMD: begin
					if (!one_hot(reg_wdata_in)) begin
						next_err     = 1'b1;
						next_cmd_err = 1'b1;
					end else begin
						cmd_set       = reg_wdata_in[CMD_SET_FAIL_BIT];
						cmd_ack       = reg_wdata_in[CMD_ACK_BIT];
						next_warn_clr = reg_wdata_in[CMD_CLR_WARN_BIT];
					end
				end
				default: next_err = 1'b1;
			endcase
		end
		if (next_warn_clr) begin
			next_cmd_err = 1'b0;
		end
		if (pd_write_in) begin
			next_pd_q = pd_data_in;
		end
		// Watchdog sequencing
		unique case (state)
			ST_IDLE: begin
				if (pd_write_in && timeout_ms != TIMEOUT_OFF) begin
					next_state = ST_RUN;
					restart    = 1'b1;
				end
			end
			ST_RUN: begin
				if (pd_write_in) begin
					restart = 1'b1;
				end else if (tick && (ms_cnt + 16'h0001) >= timeout_ms) begin
					expire = 1'b1;
				end
			end
			ST_FAIL: begin
				if (cmd_ack || (auto_confirm_in && pd_write_in)) begin
					next_state = (timeout_ms != TIMEOUT_OFF) ? ST_RUN : ST_IDLE;
					restart    = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Failure causes, user command first; a cause beats a same-cycle clear
		if (cmd_set) begin
			fail_evt = 1'b1;
			fail_rsn = RSN_USER;
		end else if (expire) begin
			fail_evt = 1'b1;
			fail_rsn = RSN_WDOG;
		end else if (modbus_timeout_in) begin
			fail_evt = 1'b1;
			fail_rsn = RSN_MODBUS;
		end
		if (fail_evt && (state != ST_FAIL || next_state != ST_FAIL)) begin
			next_state               = ST_FAIL;
			next_failure_reason_code = fail_rsn;
			next_fail_mode           = fault_response_mode[1:0];
			next_hold_q              = pd_q;
		end
		// Millisecond counter runs only while armed
		if (restart) begin
			next_presc  = '0;
			next_ms_cnt = 16'h0000;
		end else if (next_state == ST_RUN) begin
			next_presc = tick ? '0 : presc + PW'(1);
			if (tick && ms_cnt != 16'hffff) begin
				next_ms_cnt = ms_cnt + 16'h0001;
			end
		end
		next_out = (next_state == ST_FAIL) ?
			subst(next_fail_mode, next_hold_q) : next_pd_q;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state               <= ST_IDLE;
			timeout_ms          <= RST_TIMEOUT;
			fault_response_mode <= RST_MODE;
			failure_reason_code <= RST_REASON;
			presc               <= '0;
			ms_cnt              <= 16'h0000;
			pd_q                <= '0;
			hold_q              <= '0;
			fail_mode           <= 2'h0;
			cmd_err             <= 1'b0;
			reg_rdata_out       <= 16'h0000;
			reg_ack_out         <= 1'b0;
			reg_err_out         <= 1'b0;
			out_value_out       <= '0;
			net_fail_out        <= 1'b0;
			io_warn_clear_out   <= 1'b0;
		end else begin
			state               <= next_state;
			timeout_ms          <= next_timeout_ms;
			fault_response_mode <= next_fault_response_mode;
			failure_reason_code <= next_failure_reason_code;
			presc               <= next_presc;
			ms_cnt              <= next_ms_cnt;
			pd_q                <= next_pd_q;
			hold_q              <= next_hold_q;
			fail_mode           <= next_fail_mode;
			cmd_err             <= next_cmd_err;
			reg_rdata_out       <= next_rdata;
			reg_ack_out         <= next_ack;
			reg_err_out         <= next_err;
			out_value_out       <= next_out;
			net_fail_out        <= (next_state == ST_FAIL);
			io_warn_clear_out   <= next_warn_clr;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	AST_TMO_RANGE: assert property (reg_wr_in && !reg_rd_in && reg_addr_in == ADDR_TIMEOUT &&
		reg_wdata_in != TIMEOUT_OFF &&
		(reg_wdata_in < TIMEOUT_MIN_MS || reg_wdata_in > TIMEOUT_MAX_MS)
		|=> reg_err_out && timeout_ms == $past(timeout_ms))
		else $error("out-of-range timeout accepted");
	AST_ZERO_OFF: assert property (timeout_ms == TIMEOUT_OFF && state == ST_IDLE
		|=> state != ST_RUN)
		else $error("watchdog armed with zero timeout");
	AST_MODE_LOW: assert property (net_fail_out && fail_mode == MODE_LOW[1:0]
		|-> out_value_out == '0)
		else $error("low substitute not applied");
	AST_MODE_HOLD: assert property (net_fail_out && fail_mode == MODE_HOLD[1:0]
		|-> out_value_out == hold_q)
		else $error("hold substitute not applied");
	AST_MODE_WR: assert property (reg_wr_in && !reg_rd_in && reg_addr_in == ADDR_MODE &&
		reg_wdata_in <= MODE_HOLD |=> fault_response_mode == $past(reg_wdata_in))
		else $error("mode write lost");
	AST_CMD_MULTI: assert property (reg_wr_in && !reg_rd_in && reg_addr_in == ADDR_CMD &&
		!one_hot(reg_wdata_in) && !pd_write_in && !modbus_timeout_in && !tick
		|=> reg_err_out && state == $past(state) && !io_warn_clear_out)
		else $error("multi-bit command executed");
	AST_CMD_RD: assert property (reg_rd_in && reg_addr_in == ADDR_CMD
		|=> reg_err_out && reg_rdata_out == 16'h0000)
		else $error("command register readable");
	AST_RD_NO_RESTART: assert property (state == ST_RUN && !pd_write_in &&
		presc != PLAST && !modbus_timeout_in && !(reg_wr_in && !reg_rd_in)
		|=> presc == $past(presc) + PW'(1))
		else $error("watchdog restarted without write");
	AST_EXPIRE: assert property (expire && !cmd_set |-> tick ##1
		net_fail_out && failure_reason_code == RSN_WDOG)
		else $error("expiry did not raise failure");
	AST_ACK: assert property (state == ST_FAIL && cmd_ack && !modbus_timeout_in &&
		timeout_ms != TIMEOUT_OFF |=> state == ST_RUN && ms_cnt == 16'h0000 && !net_fail_out)
		else $error("acknowledge did not restart watchdog");
	AST_MANUAL: assert property (state == ST_FAIL && !auto_confirm_in && !cmd_ack
		|=> net_fail_out)
		else $error("failure cleared without acknowledge");
	AST_STATUS: assert property (reg_rd_in && reg_addr_in == ADDR_STATUS
		|=> reg_rdata_out[STAT_FAIL_BIT] == $past(state == ST_FAIL) &&
		reg_rdata_out[STAT_ERR_BIT] == $past(diag_error_in | cmd_err | (state == ST_FAIL)))
		else $error("status word wrong");

	COV_EXPIRE: cover property (expire);
	COV_AUTO_CLR: cover property (state == ST_FAIL && auto_confirm_in && pd_write_in);
	COV_USER_FAIL: cover property (cmd_set ##1 net_fail_out);
	COV_ACK: cover property (net_fail_out && cmd_ack);

endmodule : wdn_watchdog

// ### verif/wdn_client_model.sv
// Remote client model: register accesses and output process data writes
module wdn_client_model (
	// Clock
	input  wire logic        clk_in,
	// Register requests and answers
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	output logic [15:0]      reg_addr_out,
	output logic [15:0]      reg_wdata_out,
	input  wire logic [15:0] reg_rdata_in,
	input  wire logic        reg_ack_in,
	input  wire logic        reg_err_in,
	// Output process data
	output logic             pd_write_out,
	output logic [3:0]       pd_data_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 16'h0000;
		reg_wdata_out = 16'h0000;
		pd_write_out = 1'b0;
		pd_data_out = 4'h0;
	end

	// One-cycle request; released lines show inverted data, not the old value
	task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
		output logic ack, output logic err, output logic [15:0] rdata);
		@(negedge clk_in);
		reg_wr_out = wr;
		reg_rd_out = !wr;
		reg_addr_out = addr;
		reg_wdata_out = data;
		@(negedge clk_in);
		ack = reg_ack_in;
		err = reg_err_in;
		rdata = reg_rdata_in;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = ~addr;
		reg_wdata_out = ~data;
	endtask : access

	// One output process data write
	task automatic pd_write(input logic [3:0] d);
		@(negedge clk_in);
		pd_write_out = 1'b1;
		pd_data_out = d;
		@(negedge clk_in);
		pd_write_out = 1'b0;
		pd_data_out = ~d;
	endtask : pd_write

endmodule : wdn_client_model

// ### verif/process_data_watchdog_netfail_tb_top.sv
// Self-checking testbench of the process-data watchdog block
module process_data_watchdog_netfail_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wdn_pkg::*;

	// ------------------------------------------------------------
	// Signals and reference model state
	// ------------------------------------------------------------
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        wr, rd, pdw, mb_to, auto_cf, diag, nf, ack, err, iwc;
	logic [15:0] addr, wdata, rdata;
	logic [3:0]  pdd, outv;
	int m_fail = 0, m_reason = 0, m_mode = 0, m_cmode = 0, m_held = 0, m_last = 0, m_cerr = 0;
	int err_total = 0, tests_run = 0;
	int m_pdq[$];

	always #12.5 clk = ~clk;

	// Tick shortened to 2 cycles: a 200 ms timeout expires after 400 cycles
	wdn_watchdog #(.NOUT(4), .TICK_CYC(2)) dut_u (.clk_in(clk), .arst_n_in(arst_n),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err), .pd_write_in(pdw),
		.pd_data_in(pdd), .modbus_timeout_in(mb_to), .auto_confirm_in(auto_cf),
		.diag_error_in(diag), .out_value_out(outv), .net_fail_out(nf),
		.io_warn_clear_out(iwc));

	wdn_client_model cl_u (.clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
		.reg_ack_in(ack), .reg_err_in(err), .pd_write_out(pdw), .pd_data_out(pdd));

	// ------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [15:0] exp_out();
		if (m_fail == 0) return 16'(m_last);
		if (m_cmode == 0) return 16'h0000;
		if (m_cmode == 1) return 16'h000f;
		return 16'(m_held);
	endfunction : exp_out

	function automatic logic [15:0] exp_stat();
		return 16'((m_fail << 1) | ((diag === 1'b1 || m_cerr != 0 || m_fail != 0) ? 1 : 0));
	endfunction : exp_stat

	task automatic chk_pins();
		chk({15'h0000, nf}, 16'(m_fail));
		chk({12'h000, outv}, exp_out());
	endtask : chk_pins

	// First failure cause wins; substitute mode and data are frozen here
	task automatic m_fault(input int rsn);
		if (m_fail == 0) begin
			m_fail = 1;
			m_reason = rsn;
			m_held = m_last;
			m_cmode = m_mode;
		end
	endtask : m_fault

	task automatic reg_op(input logic w, input logic [15:0] a, input logic [15:0] d,
		input int e_err, input int e_data);
		logic k, e;
		logic [15:0] q;
		cl_u.access(w, a, d, k, e, q);
		chk({15'h0000, k}, 16'h0001);
		chk({15'h0000, e}, 16'(e_err));
		chk({15'h0000, iwc}, 16'(w && a == ADDR_CMD && d == 16'h0080));
		if (!w && e_err == 0) chk(q, 16'(e_data));
		chk_pins();
	endtask : reg_op

	task automatic pd_op(input logic [3:0] d);
		cl_u.pd_write(d);
		m_pdq.push_back(int'(d));
		m_last = m_pdq[$];
		if (m_fail != 0 && auto_cf) m_fail = 0;
		chk_pins();
	endtask : pd_op

	// Failure shows exactly 200 ticks of 2 cycles after the restart edge, not a cycle early
	task automatic expire(input int rsn);
		repeat (200) @(negedge clk);
		reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
		repeat (197) @(negedge clk);
		chk_pins();
		@(negedge clk);
		m_fault(rsn);
		chk_pins();
	endtask : expire

	task automatic results();
		$display("counts: tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Watchdog against a hung run
	// ------------------------------------------------------------
	initial begin
		#(20000 * 25);
		err_total++;
		results();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		mb_to = 1'b0;
		auto_cf = 1'b0;
		diag = 1'b0;
		void'($urandom(44231));
		repeat (6) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		reg_op(0, ADDR_TIMEOUT, 0, 0, 0);
		reg_op(0, ADDR_MODE, 0, 0, 0);
		reg_op(0, ADDR_REASON, 0, 0, 0);
		reg_op(0, ADDR_STATUS, 0, 0, 0);
		reg_op(0, ADDR_CMD, 0, 1, 0);
		reg_op(1, ADDR_REASON, 16'h0001, 1, 0);
		reg_op(1, ADDR_STATUS, 16'h0001, 1, 0);
		reg_op(0, 16'h07d8, 0, 1, 0);
		$display("test access kinds done");
		pd_op(4'($urandom));
		repeat (500) @(negedge clk);
		chk_pins();
		$display("test disabled watchdog done");
		reg_op(1, ADDR_MODE, 16'h0003, 1, 0);
		for (int m = 0; m < 3; m++) begin
			pd_op(4'($urandom));
			m_mode = m;
			reg_op(1, ADDR_MODE, 16'(m), 0, 0);
			reg_op(0, ADDR_MODE, 0, 0, m);
			m_fault(RSN_USER);
			reg_op(1, ADDR_CMD, 16'h0010, 0, 0);
			reg_op(0, ADDR_REASON, 0, 0, RSN_USER);
			reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
			pd_op(4'($urandom));
			m_fail = 0;
			reg_op(1, ADDR_CMD, 16'h0020, 0, 0);
		end
		$display("test fault modes done");
		diag = 1'b1;
		reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
		diag = 1'b0;
		m_cerr = 1;
		reg_op(1, ADDR_CMD, 16'h0030, 1, 0);
		reg_op(1, ADDR_CMD, 16'h0000, 1, 0);
		reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
		reg_op(1, ADDR_CMD, 16'h0001, 0, 0);
		m_cerr = 0;
		reg_op(1, ADDR_CMD, 16'h0080, 0, 0);
		reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
		$display("test commands done");
		reg_op(1, ADDR_TIMEOUT, 16'd199, 1, 0);
		reg_op(1, ADDR_TIMEOUT, 16'd65001, 1, 0);
		reg_op(1, ADDR_TIMEOUT, TIMEOUT_MAX_MS, 0, 0);
		reg_op(1, ADDR_TIMEOUT, TIMEOUT_MIN_MS, 0, 0);
		reg_op(0, ADDR_TIMEOUT, 0, 0, 200);
		$display("test timeout range done");
		m_mode = 1;
		reg_op(1, ADDR_MODE, 16'h0001, 0, 0);
		for (int i = 0; i < 3; i++) begin
			pd_op(4'($urandom));
			repeat (150) @(negedge clk);
			reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
			repeat (150) @(negedge clk);
		end
		pd_op(4'($urandom));
		expire(RSN_WDOG);
		reg_op(0, ADDR_REASON, 0, 0, RSN_WDOG);
		reg_op(1, ADDR_TIMEOUT, 16'h0000, 1, 0);
		auto_cf = 1'b1;
		pd_op(4'($urandom));
		auto_cf = 1'b0;
		expire(RSN_WDOG);
		pd_op(4'($urandom));
		m_fail = 0;
		reg_op(1, ADDR_CMD, 16'h0020, 0, 0);
		expire(RSN_WDOG);
		m_fail = 0;
		reg_op(1, ADDR_CMD, 16'h0020, 0, 0);
		@(negedge clk);
		mb_to = 1'b1;
		@(negedge clk);
		mb_to = 1'b0;
		m_fault(RSN_MODBUS);
		chk_pins();
		reg_op(0, ADDR_REASON, 0, 0, RSN_MODBUS);
		$display("test watchdog done");
		// Mid-run reset must drop a live failure and every setting
		@(negedge clk);
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		m_fail = 0;
		m_last = 0;
		m_mode = 0;
		chk_pins();
		arst_n = 1'b1;
		reg_op(0, ADDR_TIMEOUT, 0, 0, 0);
		reg_op(0, ADDR_MODE, 0, 0, 0);
		reg_op(0, ADDR_REASON, 0, 0, 0);
		reg_op(0, ADDR_STATUS, 0, 0, exp_stat());
		$display("test mid-run reset done");
		results();
	end

endmodule : process_data_watchdog_netfail_tb_top
